/* File: verilog/pfc_pkg.sv */
// Purpose: constants for the two-port flow control register bank
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes: field positions are shared by both port registers
package pfc_pkg;
  localparam logic [11:0] PFC_P1_OFFSET = 12'h1A0;
  localparam logic [11:0] PFC_P2_OFFSET = 12'h1A4;
  localparam int PFC_BIT_MANUAL = 0;
  localparam int PFC_BIT_TX_EN = 1;
  localparam int PFC_BIT_RX_EN = 2;
  localparam int PFC_BIT_TX_CUR = 3;
  localparam int PFC_BIT_RX_CUR = 4;
  localparam int PFC_BIT_DUPLEX = 5;
  localparam int PFC_BIT_BP_EN = 6;
  localparam logic [31:0] PFC_WMASK = 32'h0000_0047;
  localparam logic [1:0] PFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFC_RESP_SLVERR = 2'h2;
  localparam logic [31:0] PFC_RESET_DATA = 32'h0000_0000;
endpackage

/* File: verilog/pfc_port_flow_ctrl.sv */
// Purpose: per-port flow control configuration and status for switch ports 1 and 2
// Assumes: single 20 MHz clock, synchronous active-low reset, AXI4-Lite slave
// Notes: port status inputs (duplex, autoneg, link partner pause) come from logic on the same clock

// Summary of operation
// - With manual select 0 and autoneg on, the port's pause setting follows the autoneg result.
// - With manual select 0 and autoneg off, the programmed rx and tx pause enables apply.
// - With manual select 1, the programmed rx and tx pause enables apply in full duplex.
// - Bit 2 enables pause frame detection when it is in effect.
// - Bit 1 enables pause frame generation when it is in effect.
// - Bit 6 enables half-duplex backpressure on the port.
// - Read-only bit 5 shows the duplex state, 1 meaning half duplex.
// - Read-only bit 4 shows whether receive pause is in force now.
// - Read-only bit 3 shows whether transmit pause is in force now.
// - Status bits show the setting in force, manual or negotiated.
// - Writable fields load from the straps at reset, and the loader may overwrite them.
// - A loader update rewrites the affected fields to the new values.
// - Status reset values come from several straps together, not one.
// - Writes here never touch the phy advertisement pause bits.
module pfc_port_flow_ctrl
  import pfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] manual_pause_strap,
  input wire logic [1:0] full_duplex_pause_strap,
  input wire logic [1:0] backpressure_strap,
  input wire logic loader_write,
  input wire logic [1:0] loader_manual_pause,
  input wire logic [1:0] loader_full_duplex_pause,
  input wire logic [1:0] loader_backpressure,
  input wire logic [1:0] port_half_duplex,
  input wire logic [1:0] autoneg_enable,
  input wire logic [1:0] autoneg_rx_pause,
  input wire logic [1:0] autoneg_tx_pause,
  output logic [1:0] pause_rx_active,
  output logic [1:0] pause_tx_active,
  output logic [1:0] backpressure_active
);

  // per-port writable fields, index 0 is port 1 and index 1 is port 2
  logic [1:0] manual_reg;
  logic [1:0] rx_en_reg;
  logic [1:0] tx_en_reg;
  logic [1:0] bp_en_reg;
  logic strap_load_reg;
  logic [1:0] rx_cur;
  logic [1:0] tx_cur;
  logic [31:0] port_word [2];

  // write channel holding registers
  logic aw_held_reg;
  logic [11:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_p1 = aw_addr_reg == PFC_P1_OFFSET;
  wire wr_p2 = aw_addr_reg == PFC_P2_OFFSET;
  wire [1:0] wr_sel = {do_write && wr_p2, do_write && wr_p1};
  wire wr_lane0 = w_strb_reg[0];
  wire rd_take = s_axi_arvalid && !rvalid_reg;
  wire rd_p1 = s_axi_araddr == PFC_P1_OFFSET;
  wire rd_p2 = s_axi_araddr == PFC_P2_OFFSET;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // address and data may arrive in either order; each is held until both are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg <= 1'b0;
      w_data_reg <= PFC_RESET_DATA;
      w_strb_reg <= 4'h0;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= PFC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_p1 || wr_p2) ? PFC_RESP_OKAY : PFC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // fields take the synchronised strap levels at the first edge after reset is released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_load_reg <= 1'b1;
    end else begin
      strap_load_reg <= 1'b0;
    end
  end

  // straps are pins: two flops before the field load, no reset so they track the pins while reset is held
  logic [1:0] man_strap_meta_reg;
  logic [1:0] man_strap_sync_reg;
  logic [1:0] fdp_strap_meta_reg;
  logic [1:0] fdp_strap_sync_reg;
  logic [1:0] bp_strap_meta_reg;
  logic [1:0] bp_strap_sync_reg;
  always_ff @(posedge aclk) begin
    man_strap_meta_reg <= manual_pause_strap;
    man_strap_sync_reg <= man_strap_meta_reg;
    fdp_strap_meta_reg <= full_duplex_pause_strap;
    fdp_strap_sync_reg <= fdp_strap_meta_reg;
    bp_strap_meta_reg <= backpressure_strap;
    bp_strap_sync_reg <= bp_strap_meta_reg;
  end

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          manual_reg[gp] <= 1'b0;
          rx_en_reg[gp] <= 1'b0;
          tx_en_reg[gp] <= 1'b0;
          bp_en_reg[gp] <= 1'b0;
        end else if (strap_load_reg) begin
          manual_reg[gp] <= man_strap_sync_reg[gp];
          rx_en_reg[gp] <= fdp_strap_sync_reg[gp];
          tx_en_reg[gp] <= fdp_strap_sync_reg[gp];
          bp_en_reg[gp] <= bp_strap_sync_reg[gp];
        end else if (loader_write) begin
          manual_reg[gp] <= loader_manual_pause[gp];
          rx_en_reg[gp] <= loader_full_duplex_pause[gp];
          tx_en_reg[gp] <= loader_full_duplex_pause[gp];
          bp_en_reg[gp] <= loader_backpressure[gp];
        end else if (wr_sel[gp] && wr_lane0) begin
          manual_reg[gp] <= w_data_reg[PFC_BIT_MANUAL];
          tx_en_reg[gp] <= w_data_reg[PFC_BIT_TX_EN];
          rx_en_reg[gp] <= w_data_reg[PFC_BIT_RX_EN];
          bp_en_reg[gp] <= w_data_reg[PFC_BIT_BP_EN];
        end
      end

      // manual in full duplex; half duplex carries no pause frames
      assign rx_cur[gp] = port_half_duplex[gp] ? 1'b0 :
        (!manual_reg[gp] && autoneg_enable[gp]) ? autoneg_rx_pause[gp] : rx_en_reg[gp];
      assign tx_cur[gp] = port_half_duplex[gp] ? 1'b0 :
        (!manual_reg[gp] && autoneg_enable[gp]) ? autoneg_tx_pause[gp] : tx_en_reg[gp];
      assign pause_rx_active[gp] = rx_cur[gp];
      assign pause_tx_active[gp] = tx_cur[gp];
      assign backpressure_active[gp] = bp_en_reg[gp] && port_half_duplex[gp];

      // status derived from straps via fields and port state
      always_comb begin
        port_word[gp] = PFC_RESET_DATA;
        port_word[gp][PFC_BIT_MANUAL] = manual_reg[gp];
        port_word[gp][PFC_BIT_TX_EN] = tx_en_reg[gp];
        port_word[gp][PFC_BIT_RX_EN] = rx_en_reg[gp];
        port_word[gp][PFC_BIT_TX_CUR] = tx_cur[gp];
        port_word[gp][PFC_BIT_RX_CUR] = rx_cur[gp];
        port_word[gp][PFC_BIT_DUPLEX] = port_half_duplex[gp];
        port_word[gp][PFC_BIT_BP_EN] = bp_en_reg[gp];
      end
    end
  endgenerate

  // no path to phy advertisement
  // the block has no port toward the phy registers, so writes cannot reach them

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= PFC_RESET_DATA;
      rresp_reg <= PFC_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_p1 ? port_word[0] : (rd_p2 ? port_word[1] : PFC_RESET_DATA);
      rresp_reg <= (rd_p1 || rd_p2) ? PFC_RESP_OKAY : PFC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // checks
  property p_manual_rx;
    @(posedge aclk) disable iff (!aresetn)
      (manual_reg[0] && !port_half_duplex[0]) |-> (pause_rx_active[0] == rx_en_reg[0]);
  endproperty
  a_manual_rx: assert property (p_manual_rx) else $error("manual rx pause mismatch");

  property p_auto_tx;
    @(posedge aclk) disable iff (!aresetn)
      (!manual_reg[1] && autoneg_enable[1] && !port_half_duplex[1]) |-> (pause_tx_active[1] == autoneg_tx_pause[1]);
  endproperty
  a_auto_tx: assert property (p_auto_tx) else $error("autoneg tx pause mismatch");

  property p_noan_rx;
    @(posedge aclk) disable iff (!aresetn)
      (!manual_reg[1] && !autoneg_enable[1] && !port_half_duplex[1]) |-> (pause_rx_active[1] == rx_en_reg[1]);
  endproperty
  a_noan_rx: assert property (p_noan_rx) else $error("programmed rx pause not applied");

  property p_bp;
    @(posedge aclk) disable iff (!aresetn)
      (port_half_duplex[0] && bp_en_reg[0]) |-> backpressure_active[0];
  endproperty
  a_bp: assert property (p_bp) else $error("backpressure not generated");

  property p_read_p1;
    @(posedge aclk) disable iff (!aresetn)
      (rd_take && rd_p1) |=> (s_axi_rvalid && s_axi_rdata[31:7] == 25'h0 &&
        s_axi_rdata[PFC_BIT_DUPLEX] == $past(port_half_duplex[0]) &&
        s_axi_rdata[PFC_BIT_RX_CUR] == $past(rx_cur[0]));
  endproperty
  a_read_p1: assert property (p_read_p1) else $error("port 1 readback wrong");

  property p_read_p2_tx;
    @(posedge aclk) disable iff (!aresetn)
      (rd_take && rd_p2) |=> (s_axi_rdata[PFC_BIT_TX_CUR] == $past(tx_cur[1]));
  endproperty
  a_read_p2_tx: assert property (p_read_p2_tx) else $error("port 2 tx state readback wrong");

  property p_loader;
    @(posedge aclk) disable iff (!aresetn)
      (loader_write && !strap_load_reg) |=> (bp_en_reg == $past(loader_backpressure) &&
        manual_reg == $past(loader_manual_pause));
  endproperty
  a_loader: assert property (p_loader) else $error("loader values not taken");

  property p_strap;
    @(posedge aclk) disable iff (!aresetn)
      strap_load_reg |=> (rx_en_reg == $past(fdp_strap_sync_reg) && !strap_load_reg);
  endproperty
  a_strap: assert property (p_strap) else $error("strap values not loaded");

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && !wr_p1 && !wr_p2 && !loader_write && !strap_load_reg) |=> (s_axi_bvalid &&
        s_axi_bresp == PFC_RESP_SLVERR && $stable(manual_reg) && $stable(rx_en_reg) && $stable(bp_en_reg));
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write outside the bank was not ignored");

  property p_manual_tx;
    @(posedge aclk) disable iff (!aresetn)
      (manual_reg[1] && !port_half_duplex[1]) |-> (pause_tx_active[1] == tx_en_reg[1]);
  endproperty
  a_manual_tx: assert property (p_manual_tx) else $error("manual tx pause mismatch");

  property p_auto_rx;
    @(posedge aclk) disable iff (!aresetn)
      (!manual_reg[1] && autoneg_enable[1] && !port_half_duplex[1]) |-> (pause_rx_active[1] == autoneg_rx_pause[1]);
  endproperty
  a_auto_rx: assert property (p_auto_rx) else $error("autoneg rx pause mismatch");

  property p_half_quiet;
    @(posedge aclk) disable iff (!aresetn)
      port_half_duplex[0] |-> (!pause_tx_active[0] && !pause_rx_active[0]);
  endproperty
  a_half_quiet: assert property (p_half_quiet) else $error("pause frames enabled in half duplex");

  property p_bp_off;
    @(posedge aclk) disable iff (!aresetn)
      (!bp_en_reg[1] || !port_half_duplex[1]) |-> !backpressure_active[1];
  endproperty
  a_bp_off: assert property (p_bp_off) else $error("backpressure without enable");

  property p_read_p2_dup;
    @(posedge aclk) disable iff (!aresetn)
      (rd_take && rd_p2) |=> (s_axi_rdata[PFC_BIT_DUPLEX] == $past(port_half_duplex[1]));
  endproperty
  a_read_p2_dup: assert property (p_read_p2_dup) else $error("port 2 duplex readback wrong");

  property p_read_rsvd;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata[31:7] == 25'h0);
  endproperty
  a_read_rsvd: assert property (p_read_rsvd) else $error("reserved read bits not zero");

  property p_read_p2_rx;
    @(posedge aclk) disable iff (!aresetn)
      (rd_take && rd_p2) |=> (s_axi_rdata[PFC_BIT_RX_CUR] == $past(pause_rx_active[1]));
  endproperty
  a_read_p2_rx: assert property (p_read_p2_rx) else $error("port 2 rx state differs from setting in force");

  property p_strap_bp;
    @(posedge aclk) disable iff (!aresetn)
      strap_load_reg |=> (bp_en_reg == $past(bp_strap_sync_reg) && manual_reg == $past(man_strap_sync_reg) &&
        tx_en_reg == $past(fdp_strap_sync_reg));
  endproperty
  a_strap_bp: assert property (p_strap_bp) else $error("strap levels not copied into fields");

  property p_write_field;
    @(posedge aclk) disable iff (!aresetn)
      (wr_sel[0] && wr_lane0 && !loader_write && !strap_load_reg) |=>
        (tx_en_reg[0] == $past(w_data_reg[PFC_BIT_TX_EN]) && rx_en_reg[0] == $past(w_data_reg[PFC_BIT_RX_EN]));
  endproperty
  a_write_field: assert property (p_write_field) else $error("port 1 enable write lost");

endmodule

/* File: sim/pfc_port_flow_ctrl_test.sv */
// Purpose: self-checking bench for the two-port flow control register bank
// Assumes: AXI4-Lite master tasks, 20 MHz clock, synchronous active-low reset
// Notes: expected words are built by hand from the field map; status bits 3 and 4 read 0 in half duplex, bit 5 reads 1
module pfc_port_flow_ctrl_test import pfc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rx_act, tx_act, bp_act;
  logic loader_write = 1'b0;
  logic [1:0] man_strap = 2'h0, fd_strap = 2'h0, bp_strap = 2'h0, ld_man = 2'h0, ld_fd = 2'h0, ld_bp = 2'h0;
  logic [1:0] half = 2'h0, an_en = 2'h0, an_rx = 2'h0, an_tx = 2'h0;
  int n_errors = 0;
  int checked = 0;

  always #25 aclk = ~aclk;

  pfc_port_flow_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .manual_pause_strap(man_strap),
    .full_duplex_pause_strap(fd_strap), .backpressure_strap(bp_strap), .loader_write(loader_write),
    .loader_manual_pause(ld_man), .loader_full_duplex_pause(ld_fd), .loader_backpressure(ld_bp),
    .port_half_duplex(half), .autoneg_enable(an_en), .autoneg_rx_pause(an_rx), .autoneg_tx_pause(an_tx),
    .pause_rx_active(rx_act), .pause_tx_active(tx_act), .backpressure_active(bp_act));

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic give_up();
    n_errors++;
    $display("unexpected at %0t: no bus answer", $time);
    end_sim();
  endtask

  // valid and payload stay put until their own ready is seen high at an edge
  task automatic axi_write(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb,
                           input logic [1:0] exp_resp);
    logic aw_hit, w_hit, b_hit;
    awaddr <= addr;
    wdata <= data;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hit = 1'b0;
    for (int i = 0; i < 40 && !b_hit; i++) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid && bready;
      if (b_hit) check({30'h0, bresp}, {30'h0, exp_resp});
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    if (!b_hit) give_up();
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [11:0] addr, input logic [31:0] exp_data, input logic [1:0] exp_resp);
    logic ar_hit, r_hit;
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hit = 1'b0;
    for (int i = 0; i < 40 && !r_hit; i++) begin
      @(negedge aclk);
      ar_hit = arvalid && arready;
      r_hit = rvalid && rready;
      if (r_hit) check(rdata, exp_data);
      if (r_hit) check({30'h0, rresp}, {30'h0, exp_resp});
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
    end
    if (!r_hit) give_up();
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic expect_regs(input logic [31:0] p1, input logic [31:0] p2);
    axi_read(PFC_P1_OFFSET, p1, PFC_RESP_OKAY);
    axi_read(PFC_P2_OFFSET, p2, PFC_RESP_OKAY);
  endtask

  task automatic expect_out(input logic [1:0] rx, input logic [1:0] tx, input logic [1:0] bp);
    @(negedge aclk);
    check({30'h0, rx_act}, {30'h0, rx});
    check({30'h0, tx_act}, {30'h0, tx});
    check({30'h0, bp_act}, {30'h0, bp});
    @(posedge aclk);
  endtask

  // straps pass two flops, so they are set as reset starts and held through it
  task automatic do_reset(input logic [1:0] m, input logic [1:0] f, input logic [1:0] b);
    man_strap <= m;
    fd_strap <= f;
    bp_strap <= b;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  initial begin
    do_reset(2'h1, 2'h2, 2'h1);
    expect_regs(32'h0000_0041, 32'h0000_001E);
    expect_out(2'h2, 2'h2, 2'h0);
    axi_write(PFC_P1_OFFSET, 32'hFFFF_FFFF, 4'hF, PFC_RESP_OKAY);
    axi_read(PFC_P1_OFFSET, 32'h0000_005F, PFC_RESP_OKAY);
    expect_out(2'h3, 2'h3, 2'h0);
    half <= 2'h1;
    axi_read(PFC_P1_OFFSET, 32'h0000_0067, PFC_RESP_OKAY);
    expect_out(2'h2, 2'h2, 2'h1);
    an_en <= 2'h2;
    an_rx <= 2'h2;
    an_tx <= 2'h1;
    axi_read(PFC_P2_OFFSET, 32'h0000_0016, PFC_RESP_OKAY);
    expect_out(2'h2, 2'h0, 2'h1);
    axi_write(PFC_P2_OFFSET, 32'h0000_0001, 4'hF, PFC_RESP_OKAY);
    axi_read(PFC_P2_OFFSET, 32'h0000_0001, PFC_RESP_OKAY);
    axi_write(PFC_P2_OFFSET, 32'h0000_0046, 4'h0, PFC_RESP_OKAY);
    axi_read(PFC_P2_OFFSET, 32'h0000_0001, PFC_RESP_OKAY);
    axi_write(12'h1A8, 32'h0000_0047, 4'hF, PFC_RESP_SLVERR);
    axi_read(12'h1A8, 32'h0000_0000, PFC_RESP_SLVERR);
    ld_man <= 2'h0;
    ld_fd <= 2'h1;
    ld_bp <= 2'h2;
    loader_write <= 1'b1;
    @(posedge aclk);
    loader_write <= 1'b0;
    expect_regs(32'h0000_0026, 32'h0000_0050);
    expect_out(2'h2, 2'h0, 2'h0);
    // second reset in mid-run with other strap levels
    half <= 2'h0;
    an_en <= 2'h0;
    do_reset(2'h2, 2'h1, 2'h2);
    expect_regs(32'h0000_001E, 32'h0000_0041);
    expect_out(2'h1, 2'h1, 2'h0);
    end_sim();
  end
endmodule
